// ---- verilog/ssc_pkg.sv ----
// Purpose: Shared constants, types and helpers for the sync serial control block
// Assumes: 40 MHz system clock, receive clock arrives on its own pin
// Notes:   Word length select codes map to the formats listed below
package ssc_pkg;
	localparam int unsigned CLK_HZ      = 40_000_000;
	// Write-only target select, {addr_ctl_hi, addr_ctl_lo}
	localparam logic [1:0]  SEL_SECOND  = 2'h0;
	localparam logic [1:0]  SEL_THIRD   = 2'h1;
	localparam logic [1:0]  SEL_SYNC    = 2'h2;
	localparam logic [1:0]  SEL_TXFIFO  = 2'h3;
	// Second control field positions
	localparam int unsigned C2_MATCH_MODE = 0;
	localparam int unsigned C2_MATCH_INH  = 1;
	localparam int unsigned C2_ONE_BYTE   = 2;
	localparam int unsigned C2_WS_LO      = 3;
	localparam int unsigned C2_TX_SYNC    = 6;
	localparam int unsigned C2_EIE        = 7;
	// Third control field positions
	localparam int unsigned C3_EXT_SYNC   = 0;
	localparam int unsigned C3_ONE_SYNC   = 1;
	localparam int unsigned C3_CLR_CTS    = 2;
	localparam int unsigned C3_CLR_UF     = 3;
	// Reset values and maximum character length
	localparam logic [7:0]  SECOND_RESET  = 8'h00;
	localparam logic [7:0]  SYNC_RESET    = 8'h00;
	localparam logic [3:0]  LEN_MAX       = 4'h9;
	// Word length codes: 0..1 six data+parity, 2 seven plain, 3 eight plain,
	// 4..5 seven data+parity, 6..7 eight data+parity; bit 0 picks odd parity
	localparam logic [2:0]  WS_SEVEN_PLAIN = 3'h2;
	localparam logic [2:0]  WS_EIGHT_PLAIN = 3'h3;

	typedef enum logic [1:0] {RX_HUNT, RX_SECOND, RX_SYNCED} ssc_rx_state_e;

	function automatic logic [3:0] char_len(input logic [2:0] ws);
		if (ws <= WS_SEVEN_PLAIN) begin
			return 4'h7;
		end else if (ws <= 3'h5) begin
			return 4'h8;
		end
		return LEN_MAX;
	endfunction

	function automatic logic has_par(input logic [2:0] ws);
		return (ws != WS_SEVEN_PLAIN) && (ws != WS_EIGHT_PLAIN);
	endfunction

	function automatic logic [8:0] mask9(input logic [3:0] len);
		return 9'h1ff >> (LEN_MAX - len);
	endfunction

	// Build a transmit frame: len bits, parity appended when add_par is set
	function automatic logic [8:0] frame_char(input logic [7:0] d, input logic [2:0] ws,
		input logic add_par);
		logic [3:0] dl;
		logic [8:0] v;
		dl = char_len(ws) - {3'h0, add_par};
		v  = {1'b0, d} & mask9(dl);
		if (add_par) begin
			v[dl] = (^v) ^ ws[0];
		end
		return v;
	endfunction
endpackage

// ---- verilog/ssc_sync.sv ----
// Purpose: Two flip-flop synchroniser for levels entering a clock domain
// Assumes: Multi-bit inputs are quasi-static or individually meaningful
// Notes:   Only the second stage is visible outside
`timescale 1ns/1ps
module ssc_sync #(
	parameter int unsigned W = 1
) (
	input  wire logic         clk_i,
	input  wire logic         rst_n_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	logic [W-1:0] meta_q;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			meta_q <= '0;
			q_o    <= '0;
		end else begin
			meta_q <= d_i;
			q_o    <= meta_q;
		end
	end
endmodule // ssc_sync

// ---- verilog/ssc_ctrl.sv ----
// Purpose: Control registers, sync code, error status and serial framing
// Assumes: bus_enable_i is a one-cycle strobe on clk_i; rx data valid on rx clock fall
// Notes:   Configuration crosses to the receive clock as quasi-static levels
// Summary of operation
// - Register-select write routes data by two address bits to four write targets.
// - Second control loads when both address bits zero on a select write.
// - Match mode with inhibit clear pulses match output per match; inhibit holds it low.
// - Terminal-ready mode drives pin low when level bit one, else high.
// - Transfer-width bit picks one- or two-byte availability for status flags.
// - Three word-length bits choose 7, 8 or 9 bit characters including parity.
// - Underflow sends sync or all-ones; underflow pulse only with sync fill.
// - Fill characters get no parity except sync fill in nine-bit format.
// - With error enable, overrun, carrier, parity, clear-to-send, underflow raise interrupt.
// - Overrun and carrier clear after status read then receive read; parity follows read.
// - Clear-to-send and underflow interrupts clear by command bit or transmitter reset.
// - Error enable clear masks errors; reset forces error enable to zero.
// - Third control is four write-only bits at address code lo one, hi zero.
// - External sync bit disables hunting; reset returns to internal sync.
// - In external mode clear-sync inhibits receive; sync code is fill and match.
// - One-sync bit syncs on one match, else two successive sync characters.
// - Clear-CTS command clears stored status and interrupt; self-clearing, zero ignored.
// - Clear-underflow command resets underflow status and interrupt; self-clearing.
// - Sync code loads at address code hi one, lo zero; rewritable anytime.
// - Match output high one bit time from the sync character boundary.
// - Sync characters carry parity only in nine-bit format.
// - Sync-establishing characters dropped; later fills stripped or passed with parity check.
`timescale 1ns/1ps
module ssc_ctrl (
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       rx_clk_i,
	// Processor side
	input  wire logic       bus_enable_i,
	input  wire logic       reg_select_i,
	input  wire logic       rw_n_i,
	input  wire logic [7:0] data_i,
	input  wire logic       addr_ctl_lo_i,
	input  wire logic       addr_ctl_hi_i,
	input  wire logic       strip_sync_i,
	input  wire logic       clear_sync_i,
	input  wire logic       tx_reset_i,
	input  wire logic       rx_reset_i,
	input  wire logic       status_read_i,
	input  wire logic       rx_fifo_read_i,
	input  wire logic       rx_overrun_i,
	input  wire logic       rx_last_parity_err_i,
	input  wire logic       tx_char_valid_i,
	input  wire logic [7:0] tx_char_i,
	output logic            tx_take_o,
	output logic            tx_fifo_wr_o,
	output logic [7:0]      tx_fifo_data_o,
	output logic            rx_char_valid_o,
	output logic [7:0]      rx_char_o,
	output logic            rx_parity_err_o,
	output logic            one_byte_mode_o,
	output logic            dcd_stat_o,
	output logic            cts_stat_o,
	output logic            underflow_stat_o,
	output logic            err_irq_stat_o,
	output logic            irq_n_o,
	// Serial line side
	input  wire logic       rx_data_i,
	input  wire logic       tx_clk_i,
	input  wire logic       dcd_n_i,
	input  wire logic       cts_n_i,
	output logic            tx_data_o,
	output logic            underflow_o,
	output logic            match_or_term_ready_out_o
);
	logic [7:0]     second_control_q;
	logic [7:0]     sync_pattern_q;
	logic           ext_sync_q;
	logic           one_sync_q;
	logic           wr_hit;
	logic [1:0]     sel;
	logic           clr_cts_cmd;
	logic           clr_uf_cmd;
	logic [2:0]     ws;
	logic [4:0]     s_in;
	logic [4:0]     s_out;
	logic           tx_clk_s, dcd_s, cts_s, rxt_s, sm_s;
	logic           tx_clk_prev_q, dcd_prev_q, cts_prev_q, rxt_prev_q;
	logic           dcd_lat_q, cts_lat_q, ovr_q, uf_q;
	logic           ovr_arm_q, dcd_arm_q;
	logic           err_any;
	logic           tx_fall, tx_rise;
	logic [3:0]     tx_cnt_q;
	logic [8:0]     tx_sh_q;
	logic [8:0]     tx_frame;
	logic           uf_event;
	logic           uf_pend_q;

	assign sel     = {addr_ctl_hi_i, addr_ctl_lo_i};
	assign wr_hit  = bus_enable_i & reg_select_i & ~rw_n_i;
	assign ws      = second_control_q[ssc_pkg::C2_WS_LO +: 3];
	assign clr_cts_cmd = wr_hit & (sel == ssc_pkg::SEL_THIRD) & data_i[ssc_pkg::C3_CLR_CTS];
	assign clr_uf_cmd  = wr_hit & (sel == ssc_pkg::SEL_THIRD) & data_i[ssc_pkg::C3_CLR_UF];

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			second_control_q <= ssc_pkg::SECOND_RESET;
		end else if (wr_hit && sel == ssc_pkg::SEL_SECOND) begin
			second_control_q <= data_i;
		end
	end

	// Only the two mode bits are stored; the command bits act as pulses
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ext_sync_q <= 1'b0;
			one_sync_q <= 1'b0;
		end else if (wr_hit && sel == ssc_pkg::SEL_THIRD) begin
			ext_sync_q <= data_i[ssc_pkg::C3_EXT_SYNC];
			one_sync_q <= data_i[ssc_pkg::C3_ONE_SYNC];
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sync_pattern_q <= ssc_pkg::SYNC_RESET;
		end else if (wr_hit && sel == ssc_pkg::SEL_SYNC) begin
			sync_pattern_q <= data_i;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tx_fifo_wr_o   <= 1'b0;
			tx_fifo_data_o <= 8'h00;
		end else begin
			tx_fifo_wr_o <= wr_hit && sel == ssc_pkg::SEL_TXFIFO;
			if (wr_hit && sel == ssc_pkg::SEL_TXFIFO) begin
				tx_fifo_data_o <= data_i;
			end
		end
	end

	assign one_byte_mode_o = second_control_q[ssc_pkg::C2_ONE_BYTE];

	// Pins and receive-domain results into the system clock
	logic rxt_q, sm_q;
	assign s_in = {tx_clk_i, dcd_n_i, cts_n_i, rxt_q, sm_q};
	ssc_sync #(.W(5)) u_sync_sys (
		.clk_i   (clk_i),
		.rst_n_i (rst_n_i),
		.d_i     (s_in),
		.q_o     (s_out)
	);
	assign {tx_clk_s, dcd_s, cts_s, rxt_s, sm_s} = s_out;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tx_clk_prev_q <= 1'b0;
			dcd_prev_q    <= 1'b0;
			cts_prev_q    <= 1'b0;
			rxt_prev_q    <= 1'b0;
		end else begin
			tx_clk_prev_q <= tx_clk_s;
			dcd_prev_q    <= dcd_s;
			cts_prev_q    <= cts_s;
			rxt_prev_q    <= rxt_s;
		end
	end

	// Error status; a new event always wins over a clear in the same cycle
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ovr_q     <= 1'b0;
			dcd_lat_q <= 1'b0;
			ovr_arm_q <= 1'b0;
			dcd_arm_q <= 1'b0;
		end else begin
			if (rx_overrun_i) begin
				ovr_q <= 1'b1;
			end else if (rx_reset_i || (rx_fifo_read_i && ovr_arm_q)) begin
				ovr_q <= 1'b0;
			end
			if (dcd_s && !dcd_prev_q) begin
				dcd_lat_q <= 1'b1;
			end else if (rx_reset_i || (rx_fifo_read_i && dcd_arm_q)) begin
				dcd_lat_q <= 1'b0;
			end
			if (rx_reset_i || rx_fifo_read_i) begin
				ovr_arm_q <= 1'b0;
				dcd_arm_q <= 1'b0;
			end else if (status_read_i) begin
				ovr_arm_q <= ovr_q;
				dcd_arm_q <= dcd_lat_q;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cts_lat_q <= 1'b0;
			uf_q      <= 1'b0;
		end else begin
			if (cts_s && !cts_prev_q) begin
				cts_lat_q <= 1'b1;
			end else if (clr_cts_cmd || tx_reset_i) begin
				cts_lat_q <= 1'b0;
			end
			if (uf_event) begin
				uf_q <= 1'b1;
			end else if (clr_uf_cmd || tx_reset_i) begin
				uf_q <= 1'b0;
			end
		end
	end

	// After a clear the carrier and clear-to-send status bits follow the line level again
	assign dcd_stat_o       = dcd_lat_q | dcd_s;
	assign cts_stat_o       = cts_lat_q | cts_s;
	assign underflow_stat_o = uf_q;
	// Parity error is a level owned by the receive FIFO, cleared by its read
	assign err_any = ovr_q | dcd_lat_q | rx_last_parity_err_i | cts_lat_q | uf_q;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			err_irq_stat_o <= 1'b0;
			irq_n_o        <= 1'b1;
		end else begin
			err_irq_stat_o <= second_control_q[ssc_pkg::C2_EIE] & err_any;
			irq_n_o        <= ~(second_control_q[ssc_pkg::C2_EIE] & err_any);
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			match_or_term_ready_out_o <= 1'b1;
		end else if (second_control_q[ssc_pkg::C2_MATCH_MODE]) begin
			match_or_term_ready_out_o <= sm_s & ~second_control_q[ssc_pkg::C2_MATCH_INH];
		end else begin
			match_or_term_ready_out_o <= ~second_control_q[ssc_pkg::C2_MATCH_INH];
		end
	end

	// Transmitter, stepped on synchronised transmit clock edges
	assign tx_fall   = tx_clk_prev_q & ~tx_clk_s;
	assign tx_rise   = ~tx_clk_prev_q & tx_clk_s;
	assign tx_take_o = tx_fall & ~tx_reset_i & (tx_cnt_q == 4'h0) & tx_char_valid_i;
	assign uf_event  = tx_fall & ~tx_reset_i & (tx_cnt_q == 4'h0) & ~tx_char_valid_i &
		second_control_q[ssc_pkg::C2_TX_SYNC];

	always_comb begin
		if (tx_char_valid_i) begin
			tx_frame = ssc_pkg::frame_char(tx_char_i, ws, ssc_pkg::has_par(ws));
		end else if (second_control_q[ssc_pkg::C2_TX_SYNC]) begin
			tx_frame = ssc_pkg::frame_char(sync_pattern_q, ws,
				ssc_pkg::char_len(ws) == ssc_pkg::LEN_MAX);
		end else begin
			tx_frame = 9'h1ff;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tx_cnt_q  <= 4'h0;
			tx_sh_q   <= 9'h1ff;
			tx_data_o <= 1'b1;
		end else if (tx_reset_i) begin
			// Reset acts at once, not on the next transmit clock edge
			tx_cnt_q  <= 4'h0;
			tx_sh_q   <= 9'h1ff;
			tx_data_o <= 1'b1;
		end else if (tx_fall) begin
			if (tx_cnt_q == 4'h0) begin
				tx_data_o <= tx_frame[0];
				tx_sh_q   <= {1'b1, tx_frame[8:1]};
				tx_cnt_q  <= ssc_pkg::char_len(ws) - 4'h1;
			end else begin
				tx_data_o <= tx_sh_q[0];
				tx_sh_q   <= {1'b1, tx_sh_q[8:1]};
				tx_cnt_q  <= tx_cnt_q - 4'h1;
			end
		end
	end

	// Underflow pin is high for the transmit clock high phase after the fill starts
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			uf_pend_q   <= 1'b0;
			underflow_o <= 1'b0;
		end else begin
			if (uf_event) begin
				uf_pend_q <= 1'b1;
			end else if (tx_rise || tx_reset_i) begin
				uf_pend_q <= 1'b0;
			end
			if (tx_rise && uf_pend_q) begin
				underflow_o <= 1'b1;
			end else if (tx_fall) begin
				underflow_o <= 1'b0;
			end
		end
	end

	// Receive results: data is stable long before the toggle is seen here
	logic [7:0] rxc_q;
	logic       rxp_q;
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rx_char_valid_o <= 1'b0;
			rx_char_o       <= 8'h00;
			rx_parity_err_o <= 1'b0;
		end else begin
			rx_char_valid_o <= rxt_s ^ rxt_prev_q;
			if (rxt_s ^ rxt_prev_q) begin
				rx_char_o       <= rxc_q;
				rx_parity_err_o <= rxp_q;
			end
		end
	end

	// Receive domain, stepped on the falling receive clock edge
	logic                   rx_clk_n;
	logic [7:0]             r_sync;
	logic [7:0]             r_cfg;
	logic [2:0]             r_ws;
	logic                   r_one, r_ext, r_strip, r_clr, r_dcd_n;
	ssc_pkg::ssc_rx_state_e st_q;
	logic [8:0]             sh_q, sh_n, win, chr, sync_m;
	logic [3:0]             cnt_q, r_len, r_cmp, r_dl;
	logic                   tail_q, hunt_hit, chr_sync, boundary, ext_run, perr;

	assign rx_clk_n = ~rx_clk_i;
	ssc_sync #(.W(8)) u_sync_code (
		.clk_i   (rx_clk_n),
		.rst_n_i (rst_n_i),
		.d_i     (sync_pattern_q),
		.q_o     (r_sync)
	);
	ssc_sync #(.W(8)) u_sync_cfg (
		.clk_i   (rx_clk_n),
		.rst_n_i (rst_n_i),
		.d_i     ({ws, one_sync_q, ext_sync_q, strip_sync_i, clear_sync_i, dcd_n_i}),
		.q_o     (r_cfg)
	);
	assign {r_ws, r_one, r_ext, r_strip, r_clr, r_dcd_n} = r_cfg;

	assign r_len    = ssc_pkg::char_len(r_ws);
	assign r_cmp    = (r_len == ssc_pkg::LEN_MAX) ? 4'h8 : r_len;
	assign r_dl     = r_len - {3'h0, ssc_pkg::has_par(r_ws)};
	assign sh_n     = {rx_data_i, sh_q[8:1]};
	assign sync_m   = {1'b0, r_sync} & ssc_pkg::mask9(r_cmp);
	assign win      = sh_n >> (ssc_pkg::LEN_MAX - r_cmp);
	assign chr      = sh_n >> (ssc_pkg::LEN_MAX - r_len);
	assign hunt_hit = (win == sync_m);
	assign chr_sync = ((chr & ssc_pkg::mask9(r_cmp)) == sync_m);
	assign perr     = ssc_pkg::has_par(r_ws) & ((^chr) != r_ws[0]);
	// A nine-bit match completes one bit later, after the parity slot
	assign boundary = tail_q | (hunt_hit & (r_cmp == r_len));
	assign ext_run  = r_ext & ~r_dcd_n & ~r_clr;

	always_ff @(posedge rx_clk_n or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_q   <= ssc_pkg::RX_HUNT;
			sh_q   <= 9'h1ff;
			cnt_q  <= 4'h0;
			tail_q <= 1'b0;
			sm_q   <= 1'b0;
			rxc_q  <= 8'h00;
			rxp_q  <= 1'b0;
			rxt_q  <= 1'b0;
		end else begin
			sh_q <= sh_n;
			sm_q <= 1'b0;
			case (st_q)
				ssc_pkg::RX_HUNT: begin
					tail_q <= ~tail_q & hunt_hit & (r_cmp != r_len);
					sm_q   <= boundary;
					cnt_q  <= 4'h0;
					if (ext_run) begin
						st_q  <= ssc_pkg::RX_SYNCED;
						cnt_q <= 4'h1;
					end else if (boundary && !r_clr && !r_ext) begin
						st_q <= r_one ? ssc_pkg::RX_SYNCED : ssc_pkg::RX_SECOND;
					end
				end
				ssc_pkg::RX_SECOND, ssc_pkg::RX_SYNCED: begin
					tail_q <= 1'b0;
					if (r_ext ? !ext_run : r_clr) begin
						st_q  <= ssc_pkg::RX_HUNT;
						cnt_q <= 4'h0;
					end else if (cnt_q + 4'h1 == r_len) begin
						cnt_q <= 4'h0;
						sm_q  <= chr_sync;
						if (st_q == ssc_pkg::RX_SECOND) begin
							// Missed second sync: hunting resumes bit by bit from here
							st_q <= chr_sync ? ssc_pkg::RX_SYNCED : ssc_pkg::RX_HUNT;
						end else if (!(chr_sync && r_strip)) begin
							rxc_q <= 8'((chr & ssc_pkg::mask9(r_dl)) & 9'h0ff);
							rxp_q <= perr;
							rxt_q <= ~rxt_q;
						end
					end else begin
						cnt_q <= cnt_q + 4'h1;
					end
				end
				default: begin
					st_q <= ssc_pkg::RX_HUNT;
				end
			endcase
		end
	end
endmodule // ssc_ctrl

// ---- verification/ssc_ctrl_sva.sv ----
// Purpose: Port assertions for the sync serial control block
// Assumes: All checks in the clk_i domain; the receive side is seen through registered outputs
// Notes:   A shadow of the second control register is rebuilt from bus writes
`timescale 1ns/1ps
module ssc_ctrl_sva (
	input wire logic       clk_i,
	input wire logic       rst_n_i,
	input wire logic       bus_enable_i,
	input wire logic       reg_select_i,
	input wire logic       rw_n_i,
	input wire logic [7:0] data_i,
	input wire logic       addr_ctl_lo_i,
	input wire logic       addr_ctl_hi_i,
	input wire logic       tx_reset_i,
	input wire logic       rx_overrun_i,
	input wire logic       tx_fifo_wr_o,
	input wire logic [7:0] tx_fifo_data_o,
	input wire logic       one_byte_mode_o,
	input wire logic       underflow_stat_o,
	input wire logic       err_irq_stat_o,
	input wire logic       irq_n_o,
	input wire logic       tx_data_o,
	input wire logic       underflow_o,
	input wire logic       match_or_term_ready_out_o
);
	logic       wr;
	logic       wr_fifo;
	logic       wr_c2;
	logic [7:0] c2_q;
	logic [2:0] age_q;
	assign wr      = bus_enable_i & reg_select_i & ~rw_n_i;
	assign wr_fifo = wr & addr_ctl_hi_i & addr_ctl_lo_i;
	assign wr_c2   = wr & ~addr_ctl_hi_i & ~addr_ctl_lo_i;
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			c2_q <= 8'h00;
		end else if (wr_c2) begin
			c2_q <= data_i;
		end
	end
	// Saturating age of the last second-control write, so outputs may settle first
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			age_q <= 3'h0;
		end else if (wr_c2) begin
			age_q <= 3'h0;
		end else if (age_q != 3'h7) begin
			age_q <= age_q + 3'h1;
		end
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	AST_FIFO_WR: assert property (wr_fifo |=> tx_fifo_wr_o && tx_fifo_data_o == $past(data_i))
		else $error("Transmit FIFO write strobe or data wrong");
	AST_FIFO_QUIET: assert property (!wr_fifo |=> !tx_fifo_wr_o)
		else $error("Transmit FIFO write without a FIFO access");
	AST_WIDTH: assert property (wr_c2 |=> one_byte_mode_o == $past(data_i[2]))
		else $error("Transfer width bit not loaded");
	AST_TERM: assert property (age_q == 3'h7 && !c2_q[0] |-> match_or_term_ready_out_o == !c2_q[1])
		else $error("Terminal ready level wrong");
	AST_MASK: assert property (age_q >= 3'h3 && !c2_q[7] |-> irq_n_o && !err_irq_stat_o)
		else $error("Error interrupt while disabled");
	AST_IRQ_PAIR: assert property (irq_n_o != err_irq_stat_o)
		else $error("Interrupt pin and status disagree");
	AST_OVR: assert property (rx_overrun_i && c2_q[7] && age_q >= 3'h3 |-> ##2 !irq_n_o)
		else $error("Overrun did not raise interrupt");
	AST_TXRST_UF: assert property (tx_reset_i [*2] |=> !underflow_stat_o)
		else $error("Underflow status survives transmitter reset");
	AST_TXRST_MARK: assert property (tx_reset_i [*3] |-> tx_data_o)
		else $error("Line not at mark during transmitter reset");
	AST_UF_SYNC: assert property ($rose(underflow_o) |-> c2_q[6])
		else $error("Underflow pulse without sync fill");
	cover property (wr_fifo);
	cover property ($rose(underflow_o));
	cover property (!irq_n_o);
endmodule // ssc_ctrl_sva

bind ssc_ctrl ssc_ctrl_sva i_ssc_ctrl_sva (.clk_i, .rst_n_i, .bus_enable_i, .reg_select_i, .rw_n_i, .data_i,
	.addr_ctl_lo_i, .addr_ctl_hi_i, .tx_reset_i, .rx_overrun_i, .tx_fifo_wr_o, .tx_fifo_data_o,
	.one_byte_mode_o, .underflow_stat_o, .err_irq_stat_o, .irq_n_o, .tx_data_o, .underflow_o,
	.match_or_term_ready_out_o);

// ---- verification/ssc_line_model.sv ----
// Purpose: Far end of the synchronous serial line
// Assumes: Receive clock 80 ns, transmit clock 400 ns free running
// Notes:   Receive clock stands still between frames
`timescale 1ns/1ps
module ssc_line_model (
	input  wire logic tx_data_i,
	output logic      rx_clk_o,
	output logic      rx_data_o,
	output logic      tx_clk_o
);
	initial begin
		rx_clk_o = 1'b1;
		rx_data_o = 1'b0;
		tx_clk_o = 1'b0;
		forever begin
			#200;
			tx_clk_o = ~tx_clk_o;
		end
	end
	// Data moves on the rise so the falling edge samples mid-bit, LSB first
	task automatic send_byte(input logic [7:0] v);
		for (int i = 0; i < 8; i++) begin
			rx_data_o = v[i];
			#40;
			rx_clk_o = 1'b0;
			#40;
			rx_clk_o = 1'b1;
		end
		// Released line shows the inverse of the last bit, never a held value
		rx_data_o = ~v[7];
	endtask
	// Counting ones is alignment free, so the frame start need not be known
	task automatic count_ones(input int n, output int k);
		k = 0;
		repeat (n) begin
			@(posedge tx_clk_o);
			k += int'(tx_data_i);
		end
	endtask
endmodule // ssc_line_model

// ---- verification/tb.sv ----
// Purpose: Self-checking bench for the sync serial control block
// Assumes: 40 MHz clock, inputs driven 2 ns after the rising edge
// Notes:   Fill checks count ones over two whole characters
`timescale 1ns/1ps
module tb;
	logic       clk_i;
	logic       rst_n_i = 1'b0;
	logic       bus_enable_i = 1'b0, reg_select_i = 1'b0, rw_n_i = 1'b1;
	logic [7:0] data_i = 8'h00;
	logic       addr_ctl_lo_i = 1'b0, addr_ctl_hi_i = 1'b0;
	logic       strip_sync_i = 1'b0, clear_sync_i = 1'b0, rx_last_parity_err_i = 1'b0;
	logic       tx_reset_i = 1'b1, rx_reset_i = 1'b1, status_read_i = 1'b0, rx_fifo_read_i = 1'b0;
	logic       rx_overrun_i = 1'b0, tx_char_valid_i = 1'b0, dcd_n_i = 1'b0, cts_n_i = 1'b0;
	logic [7:0] tx_char_i = 8'h00;
	logic       rx_clk_i, rx_data_i, tx_clk_i, tx_take_o, tx_fifo_wr_o, rx_char_valid_o, rx_parity_err_o;
	logic [7:0] tx_fifo_data_o, rx_char_o;
	logic       one_byte_mode_o, dcd_stat_o, cts_stat_o, underflow_stat_o, err_irq_stat_o, irq_n_o;
	logic       tx_data_o, underflow_o, match_or_term_ready_out_o;
	logic [8:0] last_wr;
	logic [7:0] rx_q [$];
	int         errors = 0, checks = 0, mt_n = 0, mt_hi = 0, uf_n = 0;

	ssc_ctrl i_ssc_ctrl (.clk_i, .rst_n_i, .rx_clk_i, .bus_enable_i, .reg_select_i, .rw_n_i, .data_i,
		.addr_ctl_lo_i, .addr_ctl_hi_i, .strip_sync_i, .clear_sync_i, .tx_reset_i, .rx_reset_i,
		.status_read_i, .rx_fifo_read_i, .rx_overrun_i, .rx_last_parity_err_i, .tx_char_valid_i,
		.tx_char_i, .tx_take_o, .tx_fifo_wr_o, .tx_fifo_data_o, .rx_char_valid_o, .rx_char_o,
		.rx_parity_err_o, .one_byte_mode_o, .dcd_stat_o, .cts_stat_o, .underflow_stat_o,
		.err_irq_stat_o, .irq_n_o, .rx_data_i, .tx_clk_i, .dcd_n_i, .cts_n_i, .tx_data_o,
		.underflow_o, .match_or_term_ready_out_o);
	ssc_line_model i_ssc_line_model (.tx_data_i(tx_data_o), .rx_clk_o(rx_clk_i), .rx_data_o(rx_data_i),
		.tx_clk_o(tx_clk_i));

	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		if (rx_char_valid_o === 1'b1) begin
			rx_q.push_back(rx_char_o);
		end
		if (match_or_term_ready_out_o === 1'b1) begin
			mt_hi++;
		end
	end
	always @(posedge match_or_term_ready_out_o) mt_n++;
	always @(posedge underflow_o) uf_n++;

	task automatic complete_run();
		$display("checks=%0d errors=%0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic chk(input logic [8:0] got, input logic [8:0] exp);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
		#2;
	endtask
	// One strobe, then an idle enable cycle before any further access
	task automatic bus_op(input logic rs, input logic rwn, input logic [1:0] sel, input logic [7:0] d);
		{addr_ctl_hi_i, addr_ctl_lo_i} = sel;
		reg_select_i = rs;
		rw_n_i = rwn;
		data_i = d;
		bus_enable_i = 1'b1;
		cyc(1);
		last_wr = {tx_fifo_wr_o, tx_fifo_data_o};
		bus_enable_i = 1'b0;
		cyc(1);
	endtask
	task automatic rd(input logic fifo);
		status_read_i = ~fifo;
		rx_fifo_read_i = fifo;
		cyc(1);
		status_read_i = 1'b0;
		rx_fifo_read_i = 1'b0;
		cyc(1);
	endtask
	task automatic t_bus();
		for (int s = 0; s < 4; s++) begin
			bus_op(1'b1, 1'b0, 2'(s), 8'h04);
			chk(last_wr, (s == 3) ? 9'h104 : {1'b0, last_wr[7:0]});
		end
		chk({8'h0, one_byte_mode_o}, 9'h1);
		bus_op(1'b0, 1'b0, 2'h0, 8'h00);
		bus_op(1'b1, 1'b1, 2'h0, 8'h00);
		bus_op(1'b1, 1'b0, 2'h1, 8'h00);
		chk({8'h0, one_byte_mode_o}, 9'h1);
		bus_op(1'b1, 1'b0, 2'h0, 8'h00);
		chk({8'h0, one_byte_mode_o}, 9'h0);
	endtask
	task automatic t_term();
		bus_op(1'b1, 1'b0, 2'h0, 8'h02);
		cyc(3);
		chk({8'h0, match_or_term_ready_out_o}, 9'h0);
		bus_op(1'b1, 1'b0, 2'h0, 8'h00);
		cyc(3);
		chk({8'h0, match_or_term_ready_out_o}, 9'h1);
	endtask
	task automatic t_err();
		rx_reset_i = 1'b0;
		tx_reset_i = 1'b0;
		bus_op(1'b1, 1'b0, 2'h0, 8'h80);
		cyc(3);
		rx_overrun_i = 1'b1;
		cyc(1);
		rx_overrun_i = 1'b0;
		cyc(2);
		chk({7'h0, err_irq_stat_o, irq_n_o}, 9'h2);
		rd(1'b1);
		chk({8'h0, irq_n_o}, 9'h0);
		rd(1'b0);
		rd(1'b1);
		cyc(2);
		chk({8'h0, irq_n_o}, 9'h1);
		dcd_n_i = 1'b1;
		cyc(6);
		chk({7'h0, dcd_stat_o, irq_n_o}, 9'h2);
		dcd_n_i = 1'b0;
		rd(1'b0);
		rd(1'b1);
		cyc(6);
		chk({7'h0, dcd_stat_o, irq_n_o}, 9'h1);
		bus_op(1'b1, 1'b0, 2'h0, 8'h00);
		rx_overrun_i = 1'b1;
		cyc(1);
		rx_overrun_i = 1'b0;
		cyc(4);
		chk({7'h0, err_irq_stat_o, irq_n_o}, 9'h1);
		rd(1'b0);
		rd(1'b1);
	endtask
	task automatic t_cts();
		bus_op(1'b1, 1'b0, 2'h0, 8'h80);
		cts_n_i = 1'b1;
		cyc(6);
		chk({7'h0, cts_stat_o, irq_n_o}, 9'h2);
		bus_op(1'b1, 1'b0, 2'h1, 8'h00);
		cts_n_i = 1'b0;
		cyc(6);
		chk({7'h0, cts_stat_o, irq_n_o}, 9'h2);
		bus_op(1'b1, 1'b0, 2'h1, 8'h04);
		cyc(3);
		chk({7'h0, cts_stat_o, irq_n_o}, 9'h1);
		cts_n_i = 1'b1;
		cyc(6);
		tx_reset_i = 1'b1;
		cyc(3);
		chk({8'h0, irq_n_o}, 9'h1);
		cts_n_i = 1'b0;
	endtask
	task automatic t_tx();
		logic [2:0] ws_t [6] = '{3'h3, 3'h2, 3'h3, 3'h4, 3'h6, 3'h7};
		int         n_t  [6] = '{16, 14, 16, 16, 18, 18};
		int         e_t  [6] = '{16, 4, 6, 6, 8, 6};
		int         k;
		for (int i = 0; i < 6; i++) begin
			tx_reset_i = 1'b1;
			bus_op(1'b1, 1'b0, 2'h0, {1'b0, i > 0, ws_t[i], 3'h0});
			bus_op(1'b1, 1'b0, 2'h2, 8'h83);
			chk({8'h0, underflow_stat_o}, 9'h0);
			uf_n = 0;
			tx_reset_i = 1'b0;
			i_ssc_line_model.count_ones(27, k);
			i_ssc_line_model.count_ones(n_t[i], k);
			chk(9'(k), 9'(e_t[i]));
			chk({7'h0, uf_n > 0, underflow_stat_o}, (i > 0) ? 9'h3 : 9'h0);
		end
		// Data keeps the transmitter busy, so no new underflow can beat the clear
		tx_char_valid_i = 1'b1;
		bus_op(1'b1, 1'b0, 2'h1, 8'h00);
		chk({8'h0, underflow_stat_o}, 9'h1);
		bus_op(1'b1, 1'b0, 2'h1, 8'h08);
		chk({8'h0, underflow_stat_o}, 9'h0);
		i_ssc_line_model.count_ones(11, k);
		i_ssc_line_model.count_ones(18, k);
		chk(9'(k), 9'h2);
		tx_reset_i = 1'b1;
		tx_char_valid_i = 1'b0;
	endtask
	task automatic t_rx();
		logic [7:0] s_t [5] = '{8'hff, 8'h5a, 8'h3c, 8'h5a, 8'hff};
		logic [7:0] e_t [3] = '{8'h3c, 8'h5a, 8'hff};
		bus_op(1'b1, 1'b0, 2'h0, 8'h19);
		bus_op(1'b1, 1'b0, 2'h1, 8'h02);
		bus_op(1'b1, 1'b0, 2'h2, 8'h5a);
		rx_reset_i = 1'b0;
		cyc(4);
		rx_q = {};
		mt_n = 0;
		mt_hi = 0;
		foreach (s_t[i]) i_ssc_line_model.send_byte(s_t[i]);
		cyc(10);
		chk(9'(rx_q.size()), 9'h3);
		foreach (e_t[i]) chk({1'b0, rx_q[i]}, {1'b0, e_t[i]});
		chk(9'(mt_n), 9'h2);
		chk({8'h0, mt_hi >= 6 && mt_hi <= 8}, 9'h1);
		strip_sync_i = 1'b1;
		i_ssc_line_model.send_byte(8'h5a);
		i_ssc_line_model.send_byte(8'h3c);
		cyc(10);
		chk(9'(rx_q.size()), 9'h4);
		chk({1'b0, rx_q[3]}, 9'h03c);
		chk({8'h0, rx_parity_err_o}, 9'h0);
	endtask

	initial begin
		#1_000_000;
		errors++;
		complete_run();
	end
	initial begin
		repeat (4) @(posedge clk_i);
		#2;
		rst_n_i = 1'b1;
		t_bus();
		t_term();
		t_err();
		t_cts();
		t_tx();
		t_rx();
		complete_run();
	end
endmodule // tb
